// >>> rtl/psg_pkg.sv
package psg_pkg;

    localparam int PSG_NUM_REGS = 14;

    // register numbers on the multiplexed bus
    localparam logic [3:0] PSG_REG_TONE_A_PERIOD_LOW = 4'h0;
    localparam logic [3:0] PSG_REG_TONE_A_PERIOD_HIGH = 4'h1;
    localparam logic [3:0] PSG_REG_TONE_B_PERIOD_LOW = 4'h2;
    localparam logic [3:0] PSG_REG_TONE_B_PERIOD_HIGH = 4'h3;
    localparam logic [3:0] PSG_REG_TONE_C_PERIOD_LOW = 4'h4;
    localparam logic [3:0] PSG_REG_TONE_C_PERIOD_HIGH = 4'h5;
    localparam logic [3:0] PSG_REG_NOISE_PERIOD = 4'h6;
    localparam logic [3:0] PSG_REG_CHANNEL_MIXER = 4'h7;
    localparam logic [3:0] PSG_REG_CHANNEL_A_LEVEL = 4'h8;
    localparam logic [3:0] PSG_REG_CHANNEL_B_LEVEL = 4'h9;
    localparam logic [3:0] PSG_REG_CHANNEL_C_LEVEL = 4'ha;
    localparam logic [3:0] PSG_REG_ENVELOPE_PERIOD_LOW = 4'hb;
    localparam logic [3:0] PSG_REG_ENVELOPE_PERIOD_HIGH = 4'hc;
    localparam logic [3:0] PSG_REG_ENVELOPE_SHAPE = 4'hd;

    // implemented bits of each register, index = register number
    localparam logic [13:0][7:0] PSG_REG_MASK = {
        8'h0f, 8'hff, 8'hff, 8'h1f, 8'h1f, 8'h1f, 8'h3f,
        8'h1f, 8'h0f, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'hff
    };
    localparam logic [7:0] PSG_REG_RESET = 8'h00;

    // field positions
    localparam int PSG_LEVEL_ENV_BIT = 4;
    localparam int PSG_MIX_TONE_LSB = 0;
    localparam int PSG_MIX_NOISE_LSB = 3;
    localparam int PSG_SHAPE_CONT = 3;
    localparam int PSG_SHAPE_ATTACK = 2;
    localparam int PSG_SHAPE_ALT = 1;
    localparam int PSG_SHAPE_HOLD = 0;

    // noise shift register
    localparam logic [16:0] PSG_LFSR_SEED = 17'h0_0001;
    localparam int PSG_LFSR_TAP = 3;

    // prescaler: terminal counts for divide by 8 and by 128
    localparam logic [6:0] PSG_DIV_STD_MAX = 7'h07;
    localparam logic [6:0] PSG_DIV_SLOW_MAX = 7'h7f;
    localparam logic [1:0] PSG_SEL_FAST = 2'h1;
    localparam logic [1:0] PSG_SEL_SLOW = 2'h2;

    // output magnitude per level, 3 dB per step, index = level
    localparam logic [15:0][7:0] PSG_MAG = {
        8'hff, 8'hb5, 8'h80, 8'h5a, 8'h40, 8'h2d, 8'h20, 8'h17,
        8'h10, 8'h0b, 8'h08, 8'h06, 8'h04, 8'h03, 8'h02, 8'h00
    };

    // bus state, coded as {direction, control}
    typedef enum logic [1:0] {
        PSG_BUS_IDLE = 2'b00,
        PSG_BUS_UNUSED = 2'b01,
        PSG_BUS_WRITE = 2'b10,
        PSG_BUS_LATCH = 2'b11
    } psg_bus_t;

endpackage

// >>> rtl/psg_tone.sv
`timescale 1ns/10ps
`default_nettype none

module psg_tone
    import psg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic [11:0] period,
    output logic square
);

    typedef struct packed {
        logic [11:0] cnt;
        logic sq;
    } psg_tone_t;

    psg_tone_t cur;
    psg_tone_t next_st;
    logic wrap;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = cur;
        wrap = ({1'b0, cur.cnt} + 13'h0001) >= {1'b0, period};
        if (tick) begin
            if (wrap) begin
                next_st.cnt = 12'h000;
                next_st.sq = ~cur.sq;
            end else begin
                next_st.cnt = cur.cnt + 12'h001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_st;
        end
    end

    assign square = cur.sq;

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_tone_wrap;
        tick && wrap |=> cur.cnt == 12'h000 && cur.sq != $past(cur.sq);
    endproperty
    a_tone_wrap: assert property (p_tone_wrap) else $error("tone did not wrap and flip");

    property p_tone_quiet;
        !tick |=> $stable(cur.sq) && $stable(cur.cnt);
    endproperty
    a_tone_quiet: assert property (p_tone_quiet) else $error("tone moved without a tick");

endmodule

`default_nettype wire

// >>> rtl/psg_top.sv
`timescale 1ns/10ps
`default_nettype none

// Contract
// - fourteen writable registers hold all sound settings except the prescaler divide, which the select pins set
// - tone period is coarse nibble over fine byte
// - tone counter wraps at period, flips square
// - noise from seventeen bit shift register
// - five bit counter sets noise shift rate
// - mixer picks tone and noise per channel
// - level register gives fixed or envelope amplitude
// - envelope rate from sixteen bit period counter
// - four bit shape, eight distinct waveforms
// - one envelope shared by enabled channels
// - sixteen levels spaced three dB apart
// - both lines high latch register number
// - direction high alone writes latched register
// - select pins choose divide 8, 1, 128
// - standard tone period is sixteen clocks per count
module psg_top
    import psg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] shared_bus,
    input wire logic bus_direction_line,
    input wire logic bus_control_line,
    input wire logic prescale_select_low,
    input wire logic prescale_select_high,
    output logic channel_a_out,
    output logic channel_b_out,
    output logic channel_c_out,
    output logic [3:0] channel_a_amplitude,
    output logic [3:0] channel_b_amplitude,
    output logic [3:0] channel_c_amplitude,
    output logic [7:0] channel_a_magnitude,
    output logic [7:0] channel_b_magnitude,
    output logic [7:0] channel_c_magnitude
);

    typedef struct packed {
        logic [11:0] s1;
        logic [11:0] s2;
        logic [11:0] s3;
        logic [11:0] pins;
        logic [1:0] prev_bus;
        logic [7:0] addr;
        logic [13:0][7:0] regs;
        logic [6:0] pre_cnt;
        logic tick;
        logic [4:0] noise_cnt;
        logic [16:0] lfsr;
        logic [15:0] env_cnt;
        logic [3:0] env_step;
        logic env_inv;
        logic env_hold;
        logic [2:0] chan_on;
        logic [2:0][3:0] amp;
        logic [2:0][7:0] mag;
    } psg_core_t;

    psg_core_t cur;
    psg_core_t next_st;

    psg_bus_t bus_now;
    logic [1:0] sel_code;
    logic [6:0] pre_max;
    logic wr_strobe;
    logic shape_wr;
    logic noise_step;
    logic env_tick;
    logic [3:0] env_level;
    logic [2:0] tone_sq;
    logic [2:0] tone_dis;
    logic [2:0] noise_dis;
    logic [15:0] env_period;

    ////////////////////////////////////////////////////////////////
    // tone generators
    for (genvar i = 0; i < 3; i++) begin : g_tone
        psg_tone u_tone (
            .clk(clk),
            .rst(rst),
            .tick(cur.tick),
            .period({cur.regs[2 * i + 1][3:0], cur.regs[2 * i]}),
            .square(tone_sq[i])
        );
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = cur;
        bus_now = psg_bus_t'(cur.pins[9:8]);
        sel_code = cur.pins[11:10];
        pre_max = (sel_code == PSG_SEL_SLOW) ? PSG_DIV_SLOW_MAX : PSG_DIV_STD_MAX;
        wr_strobe = (bus_now == PSG_BUS_WRITE) && (cur.prev_bus != PSG_BUS_WRITE);
        shape_wr = wr_strobe && (cur.addr == {4'h0, PSG_REG_ENVELOPE_SHAPE});
        noise_step = 1'b0;
        env_tick = 1'b0;
        env_period = {cur.regs[PSG_REG_ENVELOPE_PERIOD_HIGH], cur.regs[PSG_REG_ENVELOPE_PERIOD_LOW]};
        tone_dis = cur.regs[PSG_REG_CHANNEL_MIXER][PSG_MIX_TONE_LSB +: 3];
        noise_dis = cur.regs[PSG_REG_CHANNEL_MIXER][PSG_MIX_NOISE_LSB +: 3];
        env_level = (cur.regs[PSG_REG_ENVELOPE_SHAPE][PSG_SHAPE_ATTACK] ^ cur.env_inv) ?
            cur.env_step : ~cur.env_step;

        // pin synchroniser, a bit moves once stages two and three agree
        next_st.s1 = {prescale_select_high, prescale_select_low, bus_direction_line,
            bus_control_line, shared_bus};
        next_st.s2 = cur.s1;
        next_st.s3 = cur.s2;
        next_st.pins = (cur.s3 & ~(cur.s2 ^ cur.s3)) | (cur.pins & (cur.s2 ^ cur.s3));

        // bus decode, one write per entry into the write state
        next_st.prev_bus = bus_now;
        if (bus_now == PSG_BUS_LATCH) begin
            next_st.addr = cur.pins[7:0];
        end else if (wr_strobe && (cur.addr < 8'(PSG_NUM_REGS))) begin
            next_st.regs[cur.addr[3:0]] = cur.pins[7:0] & PSG_REG_MASK[cur.addr[3:0]];
        end

        // prescaler
        if (sel_code == PSG_SEL_FAST) begin
            next_st.pre_cnt = 7'h00;
            next_st.tick = 1'b1;
        end else if (cur.pre_cnt >= pre_max) begin
            next_st.pre_cnt = 7'h00;
            next_st.tick = 1'b1;
        end else begin
            next_st.pre_cnt = cur.pre_cnt + 7'h01;
            next_st.tick = 1'b0;
        end

        // noise rate counter and shift register
        if (cur.tick) begin
            if (({1'b0, cur.noise_cnt} + 6'h01) >= {1'b0, cur.regs[PSG_REG_NOISE_PERIOD][4:0]}) begin
                next_st.noise_cnt = 5'h00;
                noise_step = 1'b1;
            end else begin
                next_st.noise_cnt = cur.noise_cnt + 5'h01;
            end
        end
        if (noise_step) begin
            next_st.lfsr = {cur.lfsr[0] ^ cur.lfsr[PSG_LFSR_TAP], cur.lfsr[16:1]};
        end

        // envelope period counter
        if (cur.tick) begin
            if (({1'b0, cur.env_cnt} + 17'h0_0001) >= {1'b0, env_period}) begin
                next_st.env_cnt = 16'h0000;
                env_tick = 1'b1;
            end else begin
                next_st.env_cnt = cur.env_cnt + 16'h0001;
            end
        end

        // envelope shape sequencer
        if (shape_wr) begin
            next_st.env_cnt = 16'h0000;
            next_st.env_step = 4'h0;
            next_st.env_inv = 1'b0;
            next_st.env_hold = 1'b0;
        end else if (env_tick && !cur.env_hold) begin
            if (cur.env_step == 4'hf) begin
                if (!cur.regs[PSG_REG_ENVELOPE_SHAPE][PSG_SHAPE_CONT]) begin
                    next_st.env_hold = 1'b1;
                    next_st.env_inv = cur.regs[PSG_REG_ENVELOPE_SHAPE][PSG_SHAPE_ATTACK];
                end else if (cur.regs[PSG_REG_ENVELOPE_SHAPE][PSG_SHAPE_HOLD]) begin
                    next_st.env_hold = 1'b1;
                    next_st.env_inv = cur.env_inv ^ cur.regs[PSG_REG_ENVELOPE_SHAPE][PSG_SHAPE_ALT];
                end else begin
                    next_st.env_step = 4'h0;
                    next_st.env_inv = cur.env_inv ^ cur.regs[PSG_REG_ENVELOPE_SHAPE][PSG_SHAPE_ALT];
                end
            end else begin
                next_st.env_step = cur.env_step + 4'h1;
            end
        end

        // mixer, amplitude select and magnitude per channel
        for (int c = 0; c < 3; c++) begin
            next_st.chan_on[c] = (tone_sq[c] | tone_dis[c]) & (cur.lfsr[0] | noise_dis[c]);
            next_st.amp[c] = cur.regs[PSG_REG_CHANNEL_A_LEVEL + 4'(c)][PSG_LEVEL_ENV_BIT] ?
                env_level : cur.regs[PSG_REG_CHANNEL_A_LEVEL + 4'(c)][3:0];
            next_st.mag[c] = cur.chan_on[c] ? PSG_MAG[cur.amp[c]] : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '0;
            cur.lfsr <= PSG_LFSR_SEED;
            for (int r = 0; r < PSG_NUM_REGS; r++) begin
                cur.regs[r] <= PSG_REG_RESET;
            end
        end else begin
            cur <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////
    assign channel_a_out = cur.chan_on[0];
    assign channel_b_out = cur.chan_on[1];
    assign channel_c_out = cur.chan_on[2];
    assign channel_a_amplitude = cur.amp[0];
    assign channel_b_amplitude = cur.amp[1];
    assign channel_c_amplitude = cur.amp[2];
    assign channel_a_magnitude = cur.mag[0];
    assign channel_b_magnitude = cur.mag[1];
    assign channel_c_magnitude = cur.mag[2];

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_latch;
        bus_now == PSG_BUS_LATCH |=> cur.addr == $past(cur.pins[7:0]);
    endproperty
    a_latch: assert property (p_latch) else $error("register number not latched");

    sequence s_set_level;
        bus_now == PSG_BUS_LATCH && cur.pins[7:0] == 8'h08 ##1 wr_strobe;
    endsequence

    property p_write;
        s_set_level |=> cur.regs[8] == ($past(cur.pins[7:0]) & PSG_REG_MASK[8]);
    endproperty
    a_write: assert property (p_write) else $error("level register not written");

    property p_idle;
        bus_now == PSG_BUS_IDLE |=> $stable(cur.regs);
    endproperty
    a_idle: assert property (p_idle) else $error("register changed on idle bus");

    property p_fast;
        sel_code == PSG_SEL_FAST |=> cur.tick;
    endproperty
    a_fast: assert property (p_fast) else $error("undivided mode missed a tick");

    property p_div8;
        cur.tick && sel_code == 2'b00 |-> ##1 (!cur.tick || sel_code != 2'b00) [*7];
    endproperty
    a_div8: assert property (p_div8) else $error("divide by 8 ticked early");

    property p_noise_shift;
        noise_step |=> cur.lfsr[15:0] == $past(cur.lfsr[16:1]);
    endproperty
    a_noise_shift: assert property (p_noise_shift) else $error("noise register did not shift");

    property p_noise_alive;
        cur.lfsr != 17'h0_0000;
    endproperty
    a_noise_alive: assert property (p_noise_alive) else $error("noise register locked at zero");

    property p_noise_rest;
        !cur.tick |=> $stable(cur.lfsr);
    endproperty
    a_noise_rest: assert property (p_noise_rest) else $error("noise shifted without a tick");

    property p_mix_off;
        cur.regs[7][0] && cur.regs[7][3] |=> cur.chan_on[0];
    endproperty
    a_mix_off: assert property (p_mix_off) else $error("disabled sources did not read high");

    sequence s_shape_wr;
        shape_wr;
    endsequence

    property p_restart;
        s_shape_wr |=> cur.env_step == 4'h0 && !cur.env_hold && cur.env_cnt == 16'h0000;
    endproperty
    a_restart: assert property (p_restart) else $error("envelope did not restart");

    property p_env_hold;
        cur.env_hold && !shape_wr |=> $stable(cur.env_step) && cur.env_hold;
    endproperty
    a_env_hold: assert property (p_env_hold) else $error("held envelope moved");

    property p_shared;
        cur.regs[8][4] && cur.regs[9][4] |=> cur.amp[0] == cur.amp[1];
    endproperty
    a_shared: assert property (p_shared) else $error("channels saw different envelopes");

    property p_mag_top;
        cur.chan_on[0] && cur.amp[0] == 4'hf |=> cur.mag[0] == 8'hff;
    endproperty
    a_mag_top: assert property (p_mag_top) else $error("top level magnitude wrong");

    property p_div_gap;
        sel_code != PSG_SEL_FAST && cur.pre_cnt < pre_max |=> !cur.tick;
    endproperty
    a_div_gap: assert property (p_div_gap) else $error("prescaler ticked before its count");

    property p_slow_tick;
        sel_code == PSG_SEL_SLOW && cur.pre_cnt == PSG_DIV_SLOW_MAX |=> cur.tick;
    endproperty
    a_slow_tick: assert property (p_slow_tick) else $error("divide by 128 missed its tick");

    property p_bad_number;
        wr_strobe && cur.addr >= 8'(PSG_NUM_REGS) |=> $stable(cur.regs);
    endproperty
    a_bad_number: assert property (p_bad_number) else $error("write to unknown register landed");

    property p_write_once;
        bus_now == PSG_BUS_WRITE && cur.prev_bus == PSG_BUS_WRITE |=> $stable(cur.regs);
    endproperty
    a_write_once: assert property (p_write_once) else $error("held write state wrote again");

    property p_coarse_mask;
        wr_strobe && cur.addr == {4'h0, PSG_REG_TONE_A_PERIOD_HIGH} |=>
            cur.regs[PSG_REG_TONE_A_PERIOD_HIGH][7:4] == 4'h0;
    endproperty
    a_coarse_mask: assert property (p_coarse_mask) else $error("coarse period kept upper bits");

    property p_noise_count;
        cur.tick && !noise_step |=> cur.noise_cnt == $past(cur.noise_cnt) + 5'h01;
    endproperty
    a_noise_count: assert property (p_noise_count) else $error("noise rate counter did not count");

    property p_noise_feedback;
        noise_step |=> cur.lfsr[16] == ($past(cur.lfsr[0]) ^ $past(cur.lfsr[PSG_LFSR_TAP]));
    endproperty
    a_noise_feedback: assert property (p_noise_feedback) else $error("noise feedback bit wrong");

    property p_env_step;
        env_tick && !cur.env_hold && !shape_wr && cur.env_step != 4'hf |=>
            cur.env_step == $past(cur.env_step) + 4'h1;
    endproperty
    a_env_step: assert property (p_env_step) else $error("envelope did not step");

    property p_env_still;
        !env_tick && !shape_wr |=> $stable(cur.env_step);
    endproperty
    a_env_still: assert property (p_env_still) else $error("envelope stepped off its period");

    property p_fixed_level;
        !cur.regs[PSG_REG_CHANNEL_A_LEVEL][PSG_LEVEL_ENV_BIT] |=>
            cur.amp[0] == $past(cur.regs[PSG_REG_CHANNEL_A_LEVEL][3:0]);
    endproperty
    a_fixed_level: assert property (p_fixed_level) else $error("fixed amplitude not selected");

    property p_mag_off;
        !cur.chan_on[1] |=> cur.mag[1] == 8'h00;
    endproperty
    a_mag_off: assert property (p_mag_off) else $error("silent channel showed magnitude");

    property p_mix_both;
        !cur.regs[PSG_REG_CHANNEL_MIXER][0] && !cur.regs[PSG_REG_CHANNEL_MIXER][3] |=>
            cur.chan_on[0] == ($past(tone_sq[0]) & $past(cur.lfsr[0]));
    endproperty
    a_mix_both: assert property (p_mix_both) else $error("tone and noise not combined");

endmodule

`default_nettype wire

// >>> bench/psg_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module psg_host_model
    import psg_pkg::*;
(
    input wire logic clk,
    output logic [7:0] shared_bus,
    output logic bus_direction_line,
    output logic bus_control_line
);
    initial begin
        shared_bus = 8'h00;
        {bus_direction_line, bus_control_line} = PSG_BUS_IDLE;
    end

    ////////////////////////////////////////////////////////////////////////
    // one bus state, held long enough to cross the pin synchroniser
    task automatic hold(input psg_bus_t st, input logic [7:0] val);
        @(negedge clk);
        {bus_direction_line, bus_control_line} = st;
        shared_bus = val;
        repeat (7) @(posedge clk);
    endtask

    task automatic write_reg(input logic [7:0] num, input logic [7:0] data);
        hold(PSG_BUS_LATCH, num);
        hold(PSG_BUS_WRITE, data);
        // idle bus carries junk, never the last value
        hold(PSG_BUS_IDLE, ~data);
        // hand back at a falling edge, outputs settled
        @(negedge clk);
    endtask
endmodule

`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench
    import psg_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] sel = 2'h1;
    logic [7:0] bus;
    logic dir;
    logic ctl;
    logic a, b, c;
    logic [3:0] amp_a, amp_b, amp_c;
    logic [7:0] mag_a, mag_b, mag_c;
    logic [2:0] outs;
    int n_fail = 0;
    int n_tests = 0;
    int g, v, i;
    logic [7:0] lo [3] = '{8'h03, 8'h02, 8'h10};
    logic [7:0] hi [3] = '{8'h00, 8'hf1, 8'h00};
    logic [15:0] tone_gap [3] = '{16'h0003, 16'h0102, 16'h0010};
    logic [1:0] codes [3] = '{2'h0, 2'h3, 2'h2};
    logic [15:0] div_gap [3] = '{16'h0010, 16'h0010, 16'h0100};

    assign outs = {c, b, a};

    initial begin
        forever #5 clk = ~clk;
    end

    psg_host_model host (.clk(clk), .shared_bus(bus), .bus_direction_line(dir), .bus_control_line(ctl));

    psg_top dut (
        .clk(clk), .rst(rst), .shared_bus(bus), .bus_direction_line(dir), .bus_control_line(ctl),
        .prescale_select_low(sel[0]), .prescale_select_high(sel[1]),
        .channel_a_out(a), .channel_b_out(b), .channel_c_out(c),
        .channel_a_amplitude(amp_a), .channel_b_amplitude(amp_b), .channel_c_amplitude(amp_c),
        .channel_a_magnitude(mag_a), .channel_b_magnitude(mag_b), .channel_c_magnitude(mag_c)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // clocks in one full half period of a channel bit
    task automatic gap(input int ch, output int n);
        logic prev;
        int k;
        n = 0;
        k = 0;
        @(negedge clk);
        prev = outs[ch];
        while (outs[ch] === prev && k < 5000) begin
            @(negedge clk);
            k++;
        end
        prev = outs[ch];
        while (outs[ch] === prev && n < 5000) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic count_changes(output int cnt);
        logic prev;
        cnt = 0;
        prev = a;
        repeat (300) begin
            @(negedge clk);
            if (a !== prev) cnt++;
            prev = a;
        end
    endtask

    initial begin
        #300000;
        n_fail++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        check({12'h000, amp_a}, 16'h0000);
        check({8'h00, mag_a}, 16'h0000);
        host.write_reg(8'h07, 8'h38);
        for (i = 0; i < 3; i++) begin
            host.write_reg(8'h08 + i[7:0], 8'h0f);
            host.write_reg({i[6:0], 1'b0}, lo[i]);
            host.write_reg({i[6:0], 1'b1}, hi[i]);
            gap(i, g);
            check(g[15:0], tone_gap[i]);
        end
        // numbers past the table must not alias onto register 0
        host.write_reg(8'h0e, 8'h55);
        host.write_reg(8'hf0, 8'h77);
        gap(0, g);
        check(g[15:0], 16'h0003);
        host.write_reg(8'h00, 8'h02);
        for (i = 0; i < 3; i++) begin
            sel = codes[i];
            repeat (8) @(negedge clk);
            gap(0, g);
            check(g[15:0], div_gap[i]);
        end
        sel = 2'h1;
        host.write_reg(8'h07, 8'h24);
        for (i = 0; i < 16; i++) begin
            host.write_reg(8'h0a, i[7:0]);
            check({15'h0000, c}, 16'h0001);
            check({12'h000, amp_c}, i[15:0]);
            check({8'h00, mag_c}, {8'h00, PSG_MAG[i]});
        end
        host.write_reg(8'h07, 8'h31);
        host.write_reg(8'h06, 8'h01);
        count_changes(v);
        check({15'h0000, v > 50}, 16'h0001);
        host.write_reg(8'h06, 8'hff);
        count_changes(v);
        check({15'h0000, v <= 10}, 16'h0001);
        host.write_reg(8'h08, 8'h10);
        host.write_reg(8'h09, 8'h10);
        host.write_reg(8'h0b, 8'h00);
        host.write_reg(8'h0c, 8'h01);
        host.write_reg(8'h0d, 8'h0d);
        repeat (150) @(negedge clk);
        check({12'h000, amp_a}, 16'h0000);
        host.write_reg(8'h0c, 8'h00);
        host.write_reg(8'h0b, 8'h02);
        host.write_reg(8'h0d, 8'h0d);
        v = int'(amp_a);
        g = 0;
        while (amp_a === v[3:0] && g < 10) begin
            @(negedge clk);
            g++;
        end
        v = int'(amp_a);
        while (v < 15) begin
            @(negedge clk);
            check({12'h000, amp_a}, v[15:0]);
            @(negedge clk);
            check({12'h000, amp_a}, v[15:0] + 16'h0001);
            v++;
        end
        repeat (10) @(negedge clk);
        check({12'h000, amp_a}, 16'h000f);
        check({12'h000, amp_b}, 16'h000f);
        host.write_reg(8'h07, 8'h3f);
        check({15'h0000, b}, 16'h0001);
        check({8'h00, mag_b}, {8'h00, PSG_MAG[15]});
        check({8'h00, mag_a}, {8'h00, PSG_MAG[15]});
        host.write_reg(8'h0b, 8'h01);
        for (i = 0; i < 16; i++) begin
            host.write_reg(8'h0d, i[7:0]);
            repeat (40) @(negedge clk);
            v = int'(amp_a);
            repeat (2) @(negedge clk);
            if (!i[3] || i[0]) begin
                check({12'h000, amp_a}, (i[3] && (i[2] ^ i[1])) ? 16'h000f : 16'h0000);
            end else begin
                check({15'h0000, amp_a !== v[3:0]}, 16'h0001);
            end
        end
        // reset in mid-run clears outputs and registers
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check({13'h0000, outs}, 16'h0000);
        repeat (20) @(negedge clk);
        check({12'h000, amp_a}, 16'h0000);
        check({8'h00, mag_b}, 16'h0000);
        test_done();
    end
endmodule

`default_nettype wire
